// File: hdl/gic_command_port.sv
// Behaviour
// - answer only target address 0x55, bytes 0xAA write, 0xAB read
// - support read, incremental read, quick read, byte and incremental write
// - quick read returns byte at current address pointer
// - pointer advances on every acknowledged data byte, either side
// - multi-byte write stores into consecutive locations
// - write to read-only location is not-acknowledged after data
// - command byte above 0x6B is not-acknowledged
// - lines held low two seconds: release both lines
// - bus stuck low past timeout: drops from normal to sleep mode, unless watchdog fires that cycle
// - commands too fast trip watchdog and reset the device
// - in sleep, stretch clock up to 100 us while waking
// - in init and normal, stretch clock up to 4 ms
// - modes init, normal, sleep, shutdown change by events or command
// - commands read and write control, status and data locations
// - reset copies factory table into volatile data memory
`timescale 1ns/1ns
`default_nettype none
module gic_command_port
  import gic_pkg::*;
#(
  parameter int unsigned BUS_TO = BUS_TO_CYC,
  parameter int unsigned WD_WIN = WD_WIN_CYC,
  parameter int unsigned IDLE = IDLE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic wakeIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  output logic wdtReset,
  output gic_mode_t powerMode
);
  // link domain state
  gic_lst_t stQ, stD;
  gic_phase_t phaseQ, phaseD;
  logic [3:0] bitCntQ, bitCntD;
  logic [7:0] rxQ, rxD, txQ, txD, ptrQ, ptrD;
  logic nackQ, nackD, rdQ, rdD, firstQ, firstD;
  logic sclPQ, sdaPQ, sclOeQ, sclOeD, sdaOeQ, sdaOeD;
  logic reqTglQ, reqTglD, toTglQ, toTglD;
  gic_req_t reqQ, reqD;
  logic [CNT_W-1:0] toCntQ, toCntD, sdaCntQ, sdaCntD;
  logic linkRstN, sclS, sdaS, respTglS, shutS;
  logic sclRise, sclFall, startC, stopC, toHit, issue;
  gic_kind_t issKind;
  logic [7:0] issAddr, issData;
  // core domain state
  gic_mode_t modeQ, modeD;
  logic [7:0] copyIdxQ, copyIdxD;
  logic [11:0] wakeCntQ, wakeCntD;
  logic [CNT_W-1:0] idleCntQ, idleCntD, winCntQ, winCntD;
  logic [2:0] cmdCntQ, cmdCntD;
  gic_resp_t respQ, respD;
  logic respTglQ, respTglD, wdtQ, wdtD, shutQ;
  logic reqTglS, toTglS, wakeS, toTglP, wakeP;
  logic pending, toEvt, wakeRise, wdFire, memWe;
  logic [7:0] memA, memWd;
  logic [7:0] memQ [0:LOC_NUM-1];

  gic_sync #(.W(5)) uLinkSync (
    .clk(linkClk),
    .d({rst_n, sclIn, sdaIn, respTglQ, shutQ}),
    .q({linkRstN, sclS, sdaS, respTglS, shutS})
  );

  gic_sync #(.W(3)) uCoreSync (
    .clk(mclk),
    .d({reqTglQ, toTglQ, wakeIn}),
    .q({reqTglS, toTglS, wakeS})
  );

  assign sclRise = sclS & ~sclPQ;
  assign sclFall = ~sclS & sclPQ;
  assign startC = sclS & sclPQ & sdaPQ & ~sdaS;
  assign stopC = sclS & sclPQ & ~sdaPQ & sdaS;
  assign toHit = toCntQ == CNT_W'(BUS_TO - 1) ||
    sdaCntQ == CNT_W'(BUS_TO - 1);

  // serial engine on the link clock
  always_comb
  begin
    stD = stQ;
    phaseD = phaseQ;
    bitCntD = bitCntQ;
    rxD = rxQ;
    txD = txQ;
    ptrD = ptrQ;
    nackD = nackQ;
    rdD = rdQ;
    firstD = firstQ;
    sclOeD = sclOeQ;
    sdaOeD = sdaOeQ;
    reqTglD = reqTglQ;
    reqD = reqQ;
    toTglD = toTglQ;
    issue = 1'b0;
    issKind = K_READ;
    issAddr = ptrQ;
    issData = rxQ;
    toCntD = sclS ? '0 : toCntQ + CNT_W'(1);
    sdaCntD = sdaS ? '0 : sdaCntQ + CNT_W'(1);
    unique case (stQ)
      L_IDLE: ;
      L_RX:
      begin
        if (sclRise)
        begin
          rxD = {rxQ[6:0], sdaS};
          bitCntD = bitCntQ + 4'h1;
        end
        else if (sclFall && bitCntQ == BITS_BYTE)
        begin
          unique case (phaseQ)
            P_ADDR:
            begin
              if (rxQ[7:1] != DEV_ADDR || shutS)
                stD = L_IDLE;
              else if (rxQ[0])
              begin
                rdD = 1'b1;
                firstD = 1'b1;
                issue = 1'b1;
              end
              else
              begin
                rdD = 1'b0;
                nackD = 1'b0;
                sdaOeD = 1'b1;
                phaseD = P_CMD;
                stD = L_ACKO;
              end
            end
            P_CMD:
            begin
              if (rxQ > LOC_LAST)
              begin
                nackD = 1'b1;
                stD = L_ACKO;
              end
              else
              begin
                ptrD = rxQ;
                phaseD = P_DATA;
                issue = 1'b1;
                issKind = K_CMD;
                issAddr = rxQ;
              end
            end
            default:
            begin
              issue = 1'b1;
              issKind = K_WRITE;
            end
          endcase
        end
      end
      L_HOLD:
      begin
        if (respTglS == reqTglQ)
        begin
          sclOeD = 1'b0;
          bitCntD = '0;
          if (rdQ)
          begin
            txD = respQ.data;
            nackD = 1'b0;
            sdaOeD = firstQ ? 1'b1 : ~respQ.data[7];
            stD = firstQ ? L_ACKO : L_TX;
          end
          else
          begin
            nackD = respQ.err;
            sdaOeD = ~respQ.err;
            stD = L_ACKO;
            if (reqQ.kind == K_WRITE && !respQ.err)
              ptrD = ptrQ + 8'h1;
          end
        end
      end
      L_ACKO:
      begin
        if (sclFall)
        begin
          firstD = 1'b0;
          bitCntD = '0;
          stD = nackQ ? L_IDLE : (rdQ ? L_TX : L_RX);
          sdaOeD = (!nackQ && rdQ) ? ~txQ[7] : 1'b0;
        end
      end
      L_TX:
      begin
        if (sclFall)
        begin
          bitCntD = bitCntQ + 4'h1;
          txD = {txQ[6:0], 1'b0};
          sdaOeD = (bitCntQ == LAST_BIT) ? 1'b0 : ~txQ[6];
          if (bitCntQ == LAST_BIT)
            stD = L_ACKI;
        end
      end
      L_ACKI:
      begin
        if (sclRise)
          nackD = sdaS;
        else if (sclFall)
        begin
          if (nackQ)
            stD = L_IDLE;
          else
          begin
            ptrD = ptrQ + 8'h1;
            issue = 1'b1;
            issAddr = ptrQ + 8'h1;
          end
        end
      end
    endcase
    if (issue)
    begin
      reqD = '{kind: issKind, addr: issAddr, data: issData};
      reqTglD = ~reqTglQ;
      sclOeD = 1'b1;
      stD = L_HOLD;
    end
    if (startC)
    begin
      stD = L_RX;
      phaseD = P_ADDR;
      bitCntD = '0;
      sdaOeD = 1'b0;
    end
    if (stopC)
    begin
      stD = L_IDLE;
      sdaOeD = 1'b0;
    end
    if (toHit)
    begin
      stD = L_IDLE;
      sclOeD = 1'b0;
      sdaOeD = 1'b0;
      toTglD = ~toTglQ;
      toCntD = '0;
      sdaCntD = '0;
    end
  end

  always_ff @(posedge linkClk)
  begin
    sclPQ <= sclS;
    sdaPQ <= sdaS;
    if (!linkRstN)
    begin
      stQ <= L_IDLE;
      phaseQ <= P_ADDR;
      bitCntQ <= '0;
      rxQ <= '0;
      txQ <= '0;
      ptrQ <= '0;
      {nackQ, rdQ, firstQ, sclOeQ, sdaOeQ, reqTglQ, toTglQ} <= '0;
      reqQ <= '0;
      toCntQ <= '0;
      sdaCntQ <= '0;
    end
    else
    begin
      stQ <= stD;
      phaseQ <= phaseD;
      bitCntQ <= bitCntD;
      rxQ <= rxD;
      txQ <= txD;
      ptrQ <= ptrD;
      {nackQ, rdQ, firstQ, sclOeQ, sdaOeQ} <=
        {nackD, rdD, firstD, sclOeD, sdaOeD};
      {reqTglQ, toTglQ} <= {reqTglD, toTglD};
      reqQ <= reqD;
      toCntQ <= toCntD;
      sdaCntQ <= sdaCntD;
    end
  end

  assign pending = reqTglS != respTglQ;
  assign toEvt = toTglS != toTglP;
  assign wakeRise = wakeS & ~wakeP;

  // mode control, memory and command service on mclk
  always_comb
  begin
    modeD = modeQ;
    copyIdxD = copyIdxQ;
    wakeCntD = wakeCntQ;
    idleCntD = idleCntQ;
    cmdCntD = cmdCntQ;
    respD = respQ;
    respTglD = respTglQ;
    wdtD = 1'b0;
    wdFire = 1'b0;
    memWe = 1'b0;
    memA = reqQ.addr;
    memWd = reqQ.data;
    winCntD = winCntQ + CNT_W'(1);
    if (winCntQ == CNT_W'(WD_WIN - 1))
    begin
      winCntD = '0;
      cmdCntD = '0;
    end
    unique case (modeQ)
      M_INIT:
      begin
        memWe = 1'b1;
        memA = copyIdxQ;
        memWd = romByte(copyIdxQ);
        idleCntD = '0;
        if (copyIdxQ == LOC_LAST)
          modeD = M_NORMAL;
        else
          copyIdxD = copyIdxQ + 8'h1;
      end
      M_NORMAL:
      begin
        idleCntD = idleCntQ + CNT_W'(1);
        if (pending)
        begin
          idleCntD = '0;
          respTglD = reqTglS;
          respD = '{err: 1'b0, data: DATA_NONE};
          unique case (reqQ.kind)
            K_READ:
              if (reqQ.addr == LOC_MODE)
                respD.data = {4'h0, modeQ};
              else if (reqQ.addr <= LOC_LAST)
                respD.data = memQ[reqQ.addr[6:0]];
            K_CMD:
            begin
              cmdCntD = cmdCntQ + 3'h1;
              wdFire = cmdCntQ == CMD_PER_WIN;
            end
            default:
              if (isReadOnly(reqQ.addr))
                respD.err = 1'b1;
              else
              begin
                memWe = 1'b1;
                if (reqQ.addr == LOC_CTRL && reqQ.data == CODE_SHUTDOWN)
                  modeD = M_SHUT;
              end
          endcase
        end
        else if (idleCntQ == CNT_W'(IDLE - 1))
          modeD = M_SLEEP;
        if (toEvt)
          modeD = M_SLEEP;
      end
      M_SLEEP:
      begin
        if (pending)
        begin
          wakeCntD = wakeCntQ + 12'h1;
          if (wakeCntQ == WAKE_CYC - 12'h1)
          begin
            modeD = M_NORMAL;
            wakeCntD = '0;
          end
        end
      end
      M_SHUT:
        if (wakeRise)
        begin
          modeD = M_INIT;
          copyIdxD = '0;
        end
    endcase
    if (wdFire)
    begin
      modeD = M_INIT;
      copyIdxD = '0;
      cmdCntD = '0;
      winCntD = '0;
      respTglD = respTglQ;
      wdtD = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    toTglP <= toTglS;
    wakeP <= wakeS;
    if (memWe)
      memQ[memA[6:0]] <= memWd;
    if (!rst_n)
    begin
      modeQ <= M_INIT;
      copyIdxQ <= '0;
      wakeCntQ <= '0;
      idleCntQ <= '0;
      winCntQ <= '0;
      cmdCntQ <= '0;
      respQ <= '0;
      {respTglQ, wdtQ, shutQ} <= '0;
    end
    else
    begin
      modeQ <= modeD;
      copyIdxQ <= copyIdxD;
      wakeCntQ <= wakeCntD;
      idleCntQ <= idleCntD;
      winCntQ <= winCntD;
      cmdCntQ <= cmdCntD;
      respQ <= respD;
      {respTglQ, wdtQ, shutQ} <= {respTglD, wdtD, modeD == M_SHUT};
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclOeQ;
  assign sdaOe = sdaOeQ;
  assign wdtReset = wdtQ;
  assign powerMode = modeQ;

  // checks on the link side
  AST_ADDR_MISS: assert property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_RX && phaseQ == P_ADDR && bitCntQ == BITS_BYTE && sclFall &&
    rxQ[7:1] != DEV_ADDR && !toHit |=> stQ == L_IDLE && !sdaOeQ)
    else $error("foreign address answered");
  AST_CMD_RANGE: assert property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_RX && phaseQ == P_CMD && bitCntQ == BITS_BYTE && sclFall &&
    rxQ > LOC_LAST && !toHit |=> stQ == L_ACKO && nackQ && !sdaOeQ)
    else $error("out of range command byte acknowledged");
  AST_PTR_LOAD: assert property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_RX && phaseQ == P_CMD && bitCntQ == BITS_BYTE && sclFall &&
    rxQ <= LOC_LAST |=> ptrQ == $past(rxQ) && reqQ.kind == K_CMD)
    else $error("pointer not loaded from command byte");
  AST_PTR_READ: assert property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_ACKI && sclFall && !nackQ && !startC && !toHit
    |=> ptrQ == $past(ptrQ) + 8'h1 && reqQ.addr == ptrQ)
    else $error("pointer not advanced on controller ack");
  AST_TIMEOUT: assert property (@(posedge linkClk) disable iff (!linkRstN)
    toHit |=> stQ == L_IDLE && !sclOeQ && !sdaOeQ && toTglQ != $past(toTglQ))
    else $error("lines not released at timeout");
  AST_STRETCH: assert property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_HOLD |-> sclOeQ)
    else $error("clock stretch not held");
  AST_STRETCH_END: assert property (@(posedge linkClk)
    disable iff (!linkRstN)
    stQ == L_HOLD && respTglS == reqTglQ && !toHit |=> !sclOeQ)
    else $error("clock stretch not released");
  // checks on the core side, then covers on both the link and core clocks
  AST_RO_NACK: assert property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_NORMAL && pending && reqQ.kind == K_WRITE &&
    isReadOnly(reqQ.addr) |=> respQ.err && respTglQ == $past(reqTglS))
    else $error("read-only write not refused");
  AST_SLEEP_TO: assert property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_NORMAL && toEvt && !wdFire |=> modeQ == M_SLEEP)
    else $error("no sleep after bus timeout");
  AST_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_SLEEP ##1 modeQ == M_NORMAL
    |-> $past(wakeCntQ) == WAKE_CYC - 12'h1)
    else $error("wake delay not kept");
  AST_COPY: assert property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_INIT ##1 modeQ == M_NORMAL |-> $past(copyIdxQ) == LOC_LAST)
    else $error("left init before table copy ended");
  AST_WDT: assert property (@(posedge mclk) disable iff (!rst_n)
    wdFire |=> wdtReset && modeQ == M_INIT && copyIdxQ == 8'h0 ##1 !wdtReset)
    else $error("watchdog reset not taken");
  COV_QREAD: cover property (@(posedge linkClk) disable iff (!linkRstN)
    stQ == L_HOLD && rdQ && firstQ);
  COV_RO_NACK: cover property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_NORMAL && pending && isReadOnly(reqQ.addr));
  COV_TO: cover property (@(posedge linkClk) disable iff (!linkRstN) toHit);
  COV_WAKE: cover property (@(posedge mclk) disable iff (!rst_n)
    modeQ == M_SLEEP ##1 modeQ == M_NORMAL);
endmodule : gic_command_port
`default_nettype wire

// File: hdl/gic_pkg.sv
`default_nettype none
package gic_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h55;
  localparam logic [7:0] LOC_LAST = 8'h6b;
  localparam int LOC_NUM = 108;
  localparam logic [7:0] LOC_CTRL = 8'h00;
  localparam logic [7:0] LOC_MODE = 8'h06;
  localparam logic [7:0] RO_FIRST = 8'h02;
  localparam logic [7:0] RO_LAST = 8'h3f;
  localparam logic [7:0] CODE_SHUTDOWN = 8'h13;
  localparam logic [7:0] DATA_NONE = 8'hff;
  localparam logic [7:0] ROM_SEED = 8'h5a;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [2:0] CMD_PER_WIN = 3'h2;
  localparam int CNT_W = 25;
  // time figures and derived cycle counts
  localparam int LINK_KHZ = 6250;
  localparam int MCLK_KHZ = 25000;
  localparam int MCLK_MHZ = 25;
  localparam int BUS_TO_MS = 2000;
  localparam int BUS_TO_CYC = BUS_TO_MS * LINK_KHZ;
  localparam int WAKE_US = 100;
  localparam logic [11:0] WAKE_CYC = 12'(WAKE_US * MCLK_MHZ);
  localparam int WD_WIN_MS = 1000;
  localparam int WD_WIN_CYC = WD_WIN_MS * MCLK_KHZ;
  localparam int IDLE_MS = 1;
  localparam int IDLE_CYC = IDLE_MS * MCLK_KHZ;

  typedef enum logic [1:0] {K_READ = 2'h0, K_CMD = 2'h1, K_WRITE = 2'h2}
    gic_kind_t;
  typedef struct packed {
    gic_kind_t kind;
    logic [7:0] addr;
    logic [7:0] data;
  } gic_req_t;
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } gic_resp_t;
  typedef enum logic [3:0] {M_INIT = 4'h1, M_NORMAL = 4'h2, M_SLEEP = 4'h4,
    M_SHUT = 4'h8} gic_mode_t;
  typedef enum logic [5:0] {L_IDLE = 6'h01, L_RX = 6'h02, L_HOLD = 6'h04,
    L_ACKO = 6'h08, L_TX = 6'h10, L_ACKI = 6'h20} gic_lst_t;
  typedef enum logic [1:0] {P_ADDR = 2'h0, P_CMD = 2'h1, P_DATA = 2'h2}
    gic_phase_t;

  function automatic logic [7:0] romByte(input logic [7:0] idx);
    romByte = idx ^ ROM_SEED;
  endfunction : romByte

  function automatic logic isReadOnly(input logic [7:0] a);
    isReadOnly = (a >= RO_FIRST && a <= RO_LAST) || a > LOC_LAST;
  endfunction : isReadOnly
endpackage : gic_pkg
`default_nettype wire

// File: hdl/gic_sync.sv
`timescale 1ns/1ns
`default_nettype none
module gic_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule : gic_sync
`default_nettype wire

// File: test/gic_command_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module gic_command_port_tb_top
  import gic_pkg::*;
;
  localparam int BUS_SIM = 2000;
  localparam int WD_SIM = 15000;
  localparam int IDLE_SIM = 3000;
  logic mclk, rstN, linkClk, wakeIn, sclOut, sclOe, sdaOut, sdaOe;
  logic wdtReset, sclLow, sdaLow, sclW, sdaW;
  gic_mode_t powerMode;
  int errCount = 0;
  int checkCount = 0;
  int wdtCount = 0;
  realtime lastEnd = 0.0;
  // open-drain wires with pull-ups
  assign sclW = (sclOe ? sclOut : 1'b1) & ~sclLow;
  assign sdaW = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    linkClk = 1'b0;
    #7;
    forever #80 linkClk = ~linkClk;
  end
  gic_command_port #(.BUS_TO(BUS_SIM), .WD_WIN(WD_SIM), .IDLE(IDLE_SIM))
    dut_u (.mclk(mclk), .rst_n(rstN), .linkClk(linkClk), .sclIn(sclW),
    .sdaIn(sdaW), .wakeIn(wakeIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .wdtReset(wdtReset),
    .powerMode(powerMode));
  gic_host_model host_u (.mclk(mclk), .sclW(sclW), .sdaW(sdaW),
    .sclLow(sclLow), .sdaLow(sdaLow));
  always @(posedge mclk)
    if (wdtReset === 1'b1)
      wdtCount <= wdtCount + 1;
  task automatic finishTest();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finishTest
  task automatic chk1(input string nm, input logic e, input logic g);
    checkCount++;
    if (g !== e)
    begin
      errCount++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checkCount++;
    if (g !== e)
    begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic waitMode(input gic_mode_t m, input int lim, output int n);
    n = 0;
    while (powerMode !== m && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    checkCount++;
    if (powerMode !== m)
    begin
      errCount++;
      $display("mismatch powerMode expected %h seen %h", m, powerMode);
    end
  endtask : waitMode
  // keep command packets far enough apart for the watchdog window
  task automatic pace();
    while ($realtime < lastEnd + WD_SIM * 20.0 + 10000.0)
      @(negedge mclk);
  endtask : pace
  task automatic endCmd();
    host_u.stop();
    lastEnd = $realtime;
  endtask : endCmd
  task automatic runReset();
    int n;
    repeat (16) @(negedge mclk);
    rstN = 1'b1;
    waitMode(M_INIT, 0, n);
    waitMode(M_NORMAL, 400, n);
    chk1("copyLen", 1'b1, n >= 100);
  endtask : runReset
  task automatic runAddr();
    logic a;
    host_u.start();
    host_u.byteW(8'hac, a);
    host_u.stop();
    chk1("ackWrongAddr", 1'b0, a);
  endtask : runAddr
  task automatic runWrite();
    logic [3:0] a;
    pace();
    host_u.halfNs = 5000;
    host_u.stretchMax = 0;
    host_u.start();
    host_u.byteW(8'haa, a[3]);
    host_u.byteW(8'h40, a[2]);
    host_u.byteW(8'h12, a[1]);
    host_u.byteW(8'h34, a[0]);
    endCmd();
    host_u.halfNs = 1250;
    chk8("writeAcks", 8'h0f, {4'h0, a});
    chk1("stretch", 1'b1, host_u.stretchMax <= 100000);
  endtask : runWrite
  task automatic runRead();
    logic [2:0] a;
    logic [7:0] d0, d1, d2;
    pace();
    host_u.start();
    host_u.byteW(8'haa, a[2]);
    host_u.byteW(8'h40, a[1]);
    host_u.start();
    host_u.byteW(8'hab, a[0]);
    host_u.byteR(1'b1, d0);
    host_u.byteR(1'b1, d1);
    host_u.byteR(1'b0, d2);
    endCmd();
    chk8("readAcks", 8'h07, {5'h00, a});
    chk8("read0", 8'h12, d0);
    chk8("read1", 8'h34, d1);
    chk8("read2", 8'h42 ^ ROM_SEED, d2);
  endtask : runRead
  task automatic runQuick();
    logic a;
    logic [7:0] d0, d1;
    host_u.start();
    host_u.byteW(8'hab, a);
    host_u.byteR(1'b1, d0);
    host_u.byteR(1'b0, d1);
    host_u.stop();
    chk1("ackQuick", 1'b1, a);
    chk8("quick0", 8'h42 ^ ROM_SEED, d0);
    chk8("quick1", 8'h43 ^ ROM_SEED, d1);
  endtask : runQuick
  task automatic runSleep();
    int n;
    logic a;
    logic [7:0] d;
    waitMode(M_SLEEP, IDLE_SIM + 2000, n);
    host_u.stretchMax = 0;
    host_u.start();
    host_u.byteW(8'hab, a);
    host_u.byteR(1'b0, d);
    host_u.stop();
    chk8("sleepRead", 8'h43 ^ ROM_SEED, d);
    chk1("wakeStretch", 1'b1, host_u.stretchMax <= 2700);
  endtask : runSleep
  task automatic runRo();
    logic [2:0] a;
    pace();
    host_u.start();
    host_u.byteW(8'haa, a[2]);
    host_u.byteW(8'h10, a[1]);
    host_u.byteW(8'h55, a[0]);
    endCmd();
    chk8("roAcks", 8'h06, {5'h00, a});
  endtask : runRo
  task automatic runTimeout();
    logic r;
    logic [7:0] v;
    v = {DEV_ADDR, 1'b0};
    host_u.start();
    for (int i = 7; i >= 0; i--)
      host_u.bitX(v[i], r);
    repeat (20) @(negedge mclk);
    chk1("ackHeld", 1'b1, sdaOe);
    host_u.waitNs(BUS_SIM * 160 + 40000);
    chk1("sdaOe", 1'b0, sdaOe);
    chk1("sclOe", 1'b0, sclOe);
    chk8("stuckMode", {4'h0, M_SLEEP}, {4'h0, powerMode});
    host_u.stop();
  endtask : runTimeout
  task automatic runRange();
    logic [1:0] a, b;
    pace();
    host_u.start();
    host_u.byteW(8'haa, a[1]);
    host_u.byteW(LOC_LAST, a[0]);
    endCmd();
    pace();
    host_u.start();
    host_u.byteW(8'haa, b[1]);
    host_u.byteW(LOC_LAST + 8'h01, b[0]);
    endCmd();
    chk8("lastAcks", 8'h03, {6'h00, a});
    chk8("aboveAcks", 8'h02, {6'h00, b});
  endtask : runRange
  task automatic runShut();
    logic [2:0] a;
    logic b;
    int n;
    pace();
    host_u.start();
    host_u.byteW(8'haa, a[2]);
    host_u.byteW(LOC_CTRL, a[1]);
    host_u.byteW(CODE_SHUTDOWN, a[0]);
    endCmd();
    chk8("shutAcks", 8'h07, {5'h00, a});
    waitMode(M_SHUT, 500, n);
    host_u.start();
    host_u.byteW(8'hab, b);
    host_u.stop();
    chk1("ackInShut", 1'b0, b);
    wakeIn = 1'b1;
    repeat (10) @(negedge mclk);
    wakeIn = 1'b0;
    waitMode(M_INIT, 20, n);
    waitMode(M_NORMAL, 300, n);
  endtask : runShut
  task automatic runWdt();
    logic a;
    int base;
    base = wdtCount;
    chk1("noEarlyWdt", 1'b1, base == 0);
    repeat (5)
    begin
      host_u.start();
      host_u.byteW(8'haa, a);
      host_u.byteW(8'h40, a);
      host_u.stop();
    end
    chk1("wdtFired", 1'b1, wdtCount != base);
    chk1("ackAfterWdt", 1'b1, a);
  endtask : runWdt
  initial
  begin
    rstN = 1'b0;
    wakeIn = 1'b0;
    runReset();
    runAddr();
    runWrite();
    runRead();
    runQuick();
    runSleep();
    runRo();
    runTimeout();
    runRange();
    runShut();
    runWdt();
    finishTest();
  end
  initial
  begin
    #6000000;
    errCount++;
    $display("mismatch run expected finished seen timeout");
    finishTest();
  end
endmodule : gic_command_port_tb_top
`default_nettype wire

// File: test/gic_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module gic_host_model (
  input wire logic mclk,
  input wire logic sclW,
  input wire logic sdaW,
  output logic sclLow,
  output logic sdaLow
);
  int halfNs;
  int stretchMax;
  initial
  begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    halfNs = 1250;
    stretchMax = 0;
  end
  task automatic waitNs(input int ns);
    repeat (ns / 40) @(negedge mclk);
  endtask : waitNs
  // release scl, then wait out any stretch by the device
  task automatic sclUp();
    int n;
    n = 0;
    sclLow = 1'b0;
    @(negedge mclk);
    while (sclW !== 1'b1 && n < 150000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n > stretchMax)
      stretchMax = n;
    waitNs(halfNs);
  endtask : sclUp
  task automatic bitX(input logic b, output logic r);
    waitNs(halfNs / 4);
    sdaLow = !b;
    waitNs(halfNs * 3 / 4);
    sclUp();
    r = sdaW;
    sclLow = 1'b1;
  endtask : bitX
  // also serves as repeated start
  task automatic start();
    waitNs(halfNs / 4);
    sdaLow = 1'b0;
    waitNs(halfNs * 3 / 4);
    sclUp();
    sdaLow = 1'b1;
    waitNs(halfNs);
    sclLow = 1'b1;
  endtask : start
  task automatic stop();
    waitNs(halfNs / 4);
    sdaLow = 1'b1;
    waitNs(halfNs * 3 / 4);
    sclUp();
    sdaLow = 1'b0;
    waitNs(66000);
  endtask : stop
  task automatic byteW(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitX(d[i], r);
    bitX(1'b1, r);
    ack = !r;
  endtask : byteW
  task automatic byteR(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitX(1'b1, d[i]);
    bitX(!ack, r);
  endtask : byteR
endmodule : gic_host_model
`default_nettype wire
